// ==== irq_arbiter.sv ====
// Combinational level and polling order arbiter
`timescale 1ns/100ps
module irq_arbiter #(
   parameter int N = irq_pkg::NUM_SRC
) (
   input  wire logic [N-1:0]    req,
   input  wire logic [N-1:0]    prio_hi,
   input  wire logic [N-1:0]    prio_lo,
   output logic                 found,
   output logic [3:0]           win_slot,
   output irq_pkg::level_t      win_level
);
   import irq_pkg::*;

   // Polling rank: vector order, but the counter array moves up by two
   function automatic logic [3:0] poll_rank(input int s);
      if (s == SLOT_ARRAY) begin
         poll_rank = 4'h4;
      end else if (s == SLOT_SERIAL || s == SLOT_TMR2) begin
         poll_rank = 4'(s + 1);
      end else begin
         poll_rank = 4'(s);
      end
   endfunction

   always_comb begin
      logic [3:0] best_rank;
      level_t     lvl;
      best_rank = 4'hf;
      lvl       = 2'h0;
      found     = 1'b0;
      win_slot  = 4'h0;
      win_level = 2'h0;
      for (int s = 0; s < N; s++) begin
         lvl = {prio_hi[s], prio_lo[s]};
         if (req[s]) begin
            // Level decides first, rank only breaks ties
            if (!found || lvl > win_level ||
                (lvl == win_level && poll_rank(s) < best_rank)) begin
               found     = 1'b1;
               win_slot  = 4'(s);
               win_level = lvl;
               best_rank = poll_rank(s);
            end
         end
      end
   end

endmodule // irq_arbiter

// ==== irq_core_model.sv ====
// Far-side model: peripheral flag sources with software flag writes
`timescale 1ns/100ps
module irq_core_model (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire irq_pkg::flags_t sw_set,
   input  wire irq_pkg::flags_t sw_clr,
   input  wire logic            clear_ext0,
   input  wire logic            clear_ext1,
   input  wire logic            clear_tmr0,
   input  wire logic            clear_tmr1,
   output irq_pkg::flags_t      flags
);
   import irq_pkg::*;

   // ======================================================
   // Flag store
   // Software and hardware share one path, so a written flag is seen
   // exactly as a raised one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~sw_clr) | sw_set;
         if (clear_ext0) flags.ext_request_flag_0 <= 1'b0;
         if (clear_ext1) flags.ext_request_flag_1 <= 1'b0;
         if (clear_tmr0) flags.timer_zero_overflow_flag <= 1'b0;
         if (clear_tmr1) flags.timer_one_overflow_flag <= 1'b0;
      end
   end
endmodule // irq_core_model

// ==== irq_pkg.sv ====
// Shared constants and types for the vectored interrupt priority unit
package irq_pkg;

   // ==========================================================
   // Source slots, in vector address order
   localparam int NUM_SRC = 13;
   localparam int SLOT_EXT0   = 0;
   localparam int SLOT_TMR0   = 1;
   localparam int SLOT_EXT1   = 2;
   localparam int SLOT_TMR1   = 3;
   localparam int SLOT_SERIAL = 4;
   localparam int SLOT_TMR2   = 5;
   localparam int SLOT_ARRAY  = 6;
   localparam int SLOT_KEYPAD = 7;
   localparam int SLOT_TWOWIRE = 8;
   localparam int SLOT_SPI    = 9;
   localparam int SLOT_RSVD   = 10;
   localparam int SLOT_COMP   = 11;
   localparam int SLOT_ADC    = 12;

   // ==========================================================
   // Vector addresses
   localparam logic [15:0] RESET_VECTOR = 16'h0000;
   localparam logic [15:0] VECTOR_BASE  = 16'h0003;
   localparam logic [15:0] VECTOR_STEP  = 16'h0008;

   // ==========================================================
   // Timing: hardware call length in clock cycles
   localparam logic [2:0] CALL_CYCLES = 3'h4;

   // ==========================================================
   // Reset values
   localparam logic [3:0] ACTIVE_RESET = 4'h0;

   typedef logic [NUM_SRC-1:0] src_vec_t;
   typedef logic [1:0]         level_t;

   // Peripheral flags gathered on one carrier
   typedef struct packed {
      logic       ext_request_flag_0;
      logic       ext_request_flag_1;
      logic       timer_zero_overflow_flag;
      logic       timer_one_overflow_flag;
      logic       timer_two_overflow_flag;
      logic       timer_two_external_flag;
      logic       serial_receive_done;
      logic       serial_transmit_done;
      logic       counter_array_overflow_flag;
      logic [4:0] array_module_flags;
      logic [7:0] keypad_pin_flags;
      logic       twowire_flag;
      logic       spi_transfer_done_flag;
      logic       spi_mode_fault_flag;
      logic       spi_tx_empty_flag;
      logic       comparator_a_flag;
      logic       comparator_b_flag;
      logic       conversion_done_flag;
   } flags_t;

   // Vectoring answer to the core
   typedef struct packed {
      logic        call_start;
      logic [15:0] vector;
      logic [3:0]  slot;
      level_t      level;
   } call_t;

endpackage

// ==== irq_unit.sv ====
// Vectored interrupt priority unit top
`timescale 1ns/100ps
module irq_unit #(
   parameter int N = irq_pkg::NUM_SRC
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire irq_pkg::flags_t   flags,
   input  wire logic [N-1:0]      src_enable,
   input  wire logic              global_irq_enable,
   input  wire logic [N-1:0]      prio_high,
   input  wire logic [N-1:0]      prio_low,
   input  wire logic              ext0_edge_mode,
   input  wire logic              ext1_edge_mode,
   input  wire logic              insn_last_cycle,
   input  wire logic              return_from_interrupt,
   input  wire logic              irq_reg_write,
   output irq_pkg::call_t         call,
   output logic                   call_busy,
   output logic                   clear_ext0,
   output logic                   clear_ext1,
   output logic                   clear_tmr0,
   output logic                   clear_tmr1,
   output logic [3:0]             active_levels,
   output logic [15:0]            reset_vector
);
   import irq_pkg::*;

   // ==========================================================
   // Request gathering
   src_vec_t raw_req;
   src_vec_t req_q;
   src_vec_t gated;

   // Flags already reflect software writes, so they need no extra path
   always_comb begin
      raw_req = '0;
      raw_req[SLOT_EXT0]    = flags.ext_request_flag_0;
      raw_req[SLOT_TMR0]    = flags.timer_zero_overflow_flag;
      raw_req[SLOT_EXT1]    = flags.ext_request_flag_1;
      raw_req[SLOT_TMR1]    = flags.timer_one_overflow_flag;
      raw_req[SLOT_SERIAL]  = flags.serial_receive_done |
                              flags.serial_transmit_done;
      raw_req[SLOT_TMR2]    = flags.timer_two_overflow_flag |
                              flags.timer_two_external_flag;
      raw_req[SLOT_ARRAY]   = flags.counter_array_overflow_flag |
                              (|flags.array_module_flags);
      raw_req[SLOT_KEYPAD]  = |flags.keypad_pin_flags;
      raw_req[SLOT_TWOWIRE] = flags.twowire_flag;
      raw_req[SLOT_SPI]     = flags.spi_transfer_done_flag |
                              flags.spi_mode_fault_flag |
                              flags.spi_tx_empty_flag;
      raw_req[SLOT_COMP]    = flags.comparator_a_flag |
                              flags.comparator_b_flag;
      raw_req[SLOT_ADC]     = flags.conversion_done_flag;
      // Reserved slot never requests
      raw_req[SLOT_RSVD]    = 1'b0;
   end

   // Poll uses flag values from the preceding cycle; enables and levels are current
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
      end else begin
         req_q <= raw_req;
      end
   end

   assign gated = req_q & src_enable & {N{global_irq_enable}};

   // ==========================================================
   // Arbitration
   logic       found;
   logic [3:0] win_slot;
   level_t     win_level;

   irq_arbiter #(.N(N)) u_arb (
      .req       (gated),
      .prio_hi   (prio_high),
      .prio_lo   (prio_low),
      .found     (found),
      .win_slot  (win_slot),
      .win_level (win_level)
   );

   // ==========================================================
   // Active levels and vectoring decision
   logic [3:0] active_q;
   logic [2:0] call_cnt_q;
   logic       take;
   logic       higher_than_active;

   // Active level at or above winner blocks; level 3 active blocks all
   always_comb begin
      higher_than_active = 1'b1;
      for (int l = 0; l < 4; l++) begin
         if (active_q[l] && 2'(l) >= win_level) begin
            higher_than_active = 1'b0;
         end
      end
   end

   // Denied requests are simply re-polled next boundary, never stored
   assign take = insn_last_cycle && found && higher_than_active &&
                 !return_from_interrupt && !irq_reg_write &&
                 call_cnt_q == 3'h0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_q <= ACTIVE_RESET;
      end else begin
         if (take) begin
            active_q[win_level] <= 1'b1;
         end else if (return_from_interrupt && insn_last_cycle) begin
            // Clear only the highest active level
            if (active_q[3]) begin
               active_q[3] <= 1'b0;
            end else if (active_q[2]) begin
               active_q[2] <= 1'b0;
            end else if (active_q[1]) begin
               active_q[1] <= 1'b0;
            end else begin
               active_q[0] <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Hardware call sequencing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         call_cnt_q <= 3'h0;
      end else if (take) begin
         call_cnt_q <= CALL_CYCLES;
      end else if (call_cnt_q != 3'h0) begin
         call_cnt_q <= call_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         call <= '0;
      end else begin
         call.call_start <= take;
         if (take) begin
            call.vector <= VECTOR_BASE +
                           16'(VECTOR_STEP * {12'h000, win_slot});
            call.slot   <= win_slot;
            call.level  <= win_level;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         call_busy     <= 1'b0;
         active_levels <= ACTIVE_RESET;
         reset_vector  <= RESET_VECTOR;
      end else begin
         call_busy     <= take || call_cnt_q > 3'h1;
         active_levels <= take ? (active_q | (4'h1 << win_level))
                               : active_q;
         reset_vector  <= RESET_VECTOR;
      end
   end

   // ==========================================================
   // Hardware flag clears on vectoring
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clear_ext0 <= 1'b0;
         clear_ext1 <= 1'b0;
         clear_tmr0 <= 1'b0;
         clear_tmr1 <= 1'b0;
      end else begin
         // Level-mode externals stay owned by the requesting pin
         clear_ext0 <= take && win_slot == 4'(SLOT_EXT0) &&
                       ext0_edge_mode;
         clear_ext1 <= take && win_slot == 4'(SLOT_EXT1) &&
                       ext1_edge_mode;
         clear_tmr0 <= take && win_slot == 4'(SLOT_TMR0);
         clear_tmr1 <= take && win_slot == 4'(SLOT_TMR1);
      end
   end

   // ==========================================================
   // Checks
   chk_call_length: assert property (
      @(posedge clk) disable iff (rst)
      take |=> call_busy [*4] ##1 !call_busy)
      else $error("call busy not four cycles");

   chk_no_equal_preempt: assert property (
      @(posedge clk) disable iff (rst)
      take |-> !(|(active_q >> win_level)))
      else $error("preempted by equal or lower level");

   chk_top_level_holds: assert property (
      @(posedge clk) disable iff (rst)
      active_q[3] |-> !take)
      else $error("level three routine preempted");

   chk_block_conditions: assert property (
      @(posedge clk) disable iff (rst)
      (return_from_interrupt || irq_reg_write) |-> !take)
      else $error("vectored on blocked instruction");

   chk_global_gate: assert property (
      @(posedge clk) disable iff (rst)
      !global_irq_enable |=> !call.call_start)
      else $error("vectored with global enable low");

   chk_vector_addr: assert property (
      @(posedge clk) disable iff (rst)
      take |=> call.vector == 16'h0003 + 16'(8 * $past(win_slot)))
      else $error("wrong vector address");

   // The slot index must be today's winner, only the flags are delayed
   chk_enable_gate: assert property (
      @(posedge clk) disable iff (rst)
      take |-> src_enable[win_slot] &&
               (($past(raw_req) >> win_slot) & src_vec_t'(1)) != '0)
      else $error("vectored to disabled or idle source");

   chk_tmr_clear: assert property (
      @(posedge clk) disable iff (rst)
      (take && win_slot == 4'(SLOT_TMR0)) |=>
         clear_tmr0 ##1 !clear_tmr0)
      else $error("timer zero flag clear missing");

   chk_level_set: assert property (
      @(posedge clk) disable iff (rst)
      take |=> active_q[$past(win_level)])
      else $error("active level not recorded");

endmodule // irq_unit

// ==== vectored_interrupt_priority_unit_bench.sv ====
// Self-checking bench for the vectored interrupt priority unit
`timescale 1ns/100ps
module vectored_interrupt_priority_unit_bench;
   import irq_pkg::*;

   logic        clk = 1'b0;
   logic        rst = 1'b1;
   flags_t      flags;
   flags_t      sw_set = '0;
   flags_t      sw_clr = '0;
   logic [12:0] src_enable = '0;
   logic [12:0] prio_high = '0;
   logic [12:0] prio_low = '0;
   logic        global_irq_enable = 1'b0;
   logic        ext0_edge_mode = 1'b0;
   logic        ext1_edge_mode = 1'b0;
   logic        insn_last_cycle = 1'b0;
   logic        return_from_interrupt = 1'b0;
   logic        irq_reg_write = 1'b0;
   call_t       call;
   logic        call_busy, clear_ext0, clear_ext1, clear_tmr0, clear_tmr1;
   logic [3:0]  active_levels;
   logic [15:0] reset_vector;
   int          failures = 0;
   int          n_compared = 0;
   int          rank[13] = '{0, 1, 2, 3, 6, 4, 5, 7, 8, 9, 10, 11, 12};

   always #5 clk = ~clk;

   irq_unit #(.N(NUM_SRC)) i_dut (
      .clk(clk), .rst(rst), .flags(flags), .src_enable(src_enable),
      .global_irq_enable(global_irq_enable), .prio_high(prio_high),
      .prio_low(prio_low), .ext0_edge_mode(ext0_edge_mode),
      .ext1_edge_mode(ext1_edge_mode), .insn_last_cycle(insn_last_cycle),
      .return_from_interrupt(return_from_interrupt),
      .irq_reg_write(irq_reg_write), .call(call), .call_busy(call_busy),
      .clear_ext0(clear_ext0), .clear_ext1(clear_ext1),
      .clear_tmr0(clear_tmr0), .clear_tmr1(clear_tmr1),
      .active_levels(active_levels), .reset_vector(reset_vector));

   irq_core_model i_model (
      .clk(clk), .rst(rst), .sw_set(sw_set), .sw_clr(sw_clr),
      .clear_ext0(clear_ext0), .clear_ext1(clear_ext1),
      .clear_tmr0(clear_tmr0), .clear_tmr1(clear_tmr1), .flags(flags));

   // ======================================================
   // Reference model
   function automatic logic [12:0] src_of(flags_t f);
      logic [12:0] r;
      r = '0;
      r[0] = f.ext_request_flag_0;
      r[1] = f.timer_zero_overflow_flag;
      r[2] = f.ext_request_flag_1;
      r[3] = f.timer_one_overflow_flag;
      r[4] = f.serial_receive_done | f.serial_transmit_done;
      r[5] = f.timer_two_overflow_flag | f.timer_two_external_flag;
      r[6] = f.counter_array_overflow_flag | (|f.array_module_flags);
      r[7] = |f.keypad_pin_flags;
      r[8] = f.twowire_flag;
      r[9] = f.spi_transfer_done_flag | f.spi_mode_fault_flag
           | f.spi_tx_empty_flag;
      r[11] = f.comparator_a_flag | f.comparator_b_flag;
      r[12] = f.conversion_done_flag;
      return r;
   endfunction

   function automatic int lvl(int s);
      return {prio_high[s], prio_low[s]};
   endfunction

   function automatic int top(logic [3:0] a);
      int h;
      h = -1;
      for (int l = 0; l < 4; l++) if (a[l]) h = l;
      return h;
   endfunction

   // Rank order scan keeps the first of equal levels
   function automatic int winner(flags_t f);
      logic [12:0] r;
      int          best;
      r = src_of(f) & src_enable & {13{global_irq_enable}};
      best = -1;
      for (int i = 0; i < 13; i++) begin
         if (r[rank[i]] && (best < 0 || lvl(rank[i]) > lvl(best)))
            best = rank[i];
      end
      return best;
   endfunction

   // ======================================================
   // Checking and closing
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ======================================================
   // Stimulus
   initial begin
      int         s, got, cnt;
      logic       wr;
      logic [3:0] act, clr_cap;
      call_t      cap;
      flags_t     cur;
      void'($urandom(32'h9ad0d352));
      act = '0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      check("reset_call", call, '0);
      check("reset_active", active_levels, 4'h0);
      check("reset_vector", reset_vector, 16'h0000);
      for (int it = 0; it < 80; it++) begin
         cur = flags_t'($urandom & $urandom & $urandom);
         src_enable = 13'($urandom | $urandom);
         prio_high = 13'($urandom);
         prio_low = 13'($urandom);
         global_irq_enable = ($urandom % 8) != 0;
         ext0_edge_mode = 1'($urandom);
         ext1_edge_mode = 1'($urandom);
         wr = ($urandom % 8) == 0;
         sw_set = cur;
         @(negedge clk);
         sw_set = '0;
         repeat (2) @(negedge clk);
         insn_last_cycle = 1'b1;
         irq_reg_write = wr;
         @(negedge clk);
         insn_last_cycle = 1'b0;
         irq_reg_write = 1'b0;
         s = winner(cur);
         if (wr || s < 0 || lvl(s) <= top(act)) s = -1;
         got = 0;
         for (int i = 0; i < 4 && got == 0; i++) begin
            if (call.call_start === 1'b1) begin
               got = 1;
               cap = call;
               clr_cap = {clear_ext0, clear_ext1, clear_tmr0, clear_tmr1};
            end else begin
               @(negedge clk);
            end
         end
         cnt = 0;
         while (got == 1 && call_busy === 1'b1 && cnt < 10) begin
            cnt++;
            @(negedge clk);
         end
         check("call_start", got, s >= 0);
         if (s >= 0 && got == 1) begin
            act[lvl(s)] = 1'b1;
            check("slot", cap.slot, s);
            check("vector", cap.vector, 16'h0003 + 16'(8 * s));
            check("level", cap.level, lvl(s));
            check("clears", clr_cap, {s == 0 && ext0_edge_mode,
               s == 2 && ext1_edge_mode, s == 1, s == 3});
            check("busy", cnt, 4);
         end
         check("active", active_levels, act);
         sw_clr = '1;
         @(negedge clk);
         sw_clr = '0;
         if (act != 4'h0 && ($urandom % 2) == 1) begin
            return_from_interrupt = 1'b1;
            insn_last_cycle = 1'b1;
            @(negedge clk);
            return_from_interrupt = 1'b0;
            insn_last_cycle = 1'b0;
            act[top(act)] = 1'b0;
            @(negedge clk);
            check("return_active", active_levels, act);
         end
      end
      // A second reset drops every active level
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      check("rerun_active", active_levels, 4'h0);
      give_verdict();
   end
endmodule // vectored_interrupt_priority_unit_bench
